// ---- design/omc_mode_ctrl.sv ----
// Purpose: tracks and switches the core operating mode
// Assumes: core flags instruction boundaries and supplies mode control words
// Notes:   management entry waits for a boundary; exit restores saved context
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - reset puts the core in real-address mode before the first instruction
// - management pin or controller message enters system management mode
// - entry saves basic context and switches to a dedicated address space
// - leaving management mode restores saved context and prior mode
// - legacy 16-bit execution is a per-task attribute of protected mode
// - extended mode picks compatibility or 64-bit by code segment attribute
// - compatibility sub-mode limits linear addressing to the lowest 4 GByte
// - compatibility sub-mode uses only 16 and 32 bit address and operand sizes
// - compatibility sub-mode allows physical addresses above 4 GByte with extension
// - no legacy 16-bit tasks or hardware task switches in compatibility
// - compatibility sub-mode supports every privilege level
// - 64-bit sub-mode defaults: 64-bit address, 32-bit operand
// - in 64-bit sub-mode, extension prefix with operand override picks a 64-bit operand
// - 64-bit sub-mode exposes 16 wide registers reached via extension prefix
// - outside extended mode linear is 4 GBytes and physical 64 GBytes
// - outside 64-bit sub-mode eight general and six segment registers
// - mode and task traits come from the five mode control registers
// - application privilege may reach only the timestamp counter register
// - 64-bit sub-mode widens the instruction pointer to 64 bits
module omc_mode_ctrl
    import omc_pkg::*;
#(
    parameter int CW = CTX_W
) (
    input  wire logic          CLK_I,          // core clock
    input  wire logic          RESET_N_I,      // async reset, low
    input  wire logic          MGMT_INT_PIN_N_I, // management pin, low active
    input  wire logic          LIC_MGMT_MSG_I, // controller message, pulse
    input  wire logic          BOUNDARY_I,     // instruction boundary
    input  wire omc_ctl_t      CTL_I,          // mode control words
    input  wire logic          CS_LONG_I,      // code segment 64-bit attr
    input  wire logic          MGMT_RETURN_I,  // return from management
    input  wire logic [CW-1:0] CTX_I,          // live context
    input  wire logic          REG_EXT_PFX_I,  // extension prefix present
    input  wire logic          OPSZ_OVR_I,     // operand override present
    input  wire logic [1:0]    CPL_I,          // current privilege
    input  wire logic          MSR_REQ_I,      // register access request
    input  wire logic [31:0]   MSR_ADDR_I,     // requested register
    output omc_mode_t          MODE_O,         // current mode
    output omc_env_t           ENV_O,          // execution environment
    output logic               MGMT_SPACE_O,   // dedicated space select
    output logic               CTX_SAVE_O,     // context saved, pulse
    output logic               CTX_RESTORE_O,  // context valid, pulse
    output logic [CW-1:0]      CTX_O,          // restored context
    output logic [1:0]         OPER_SIZE_O,    // effective operand size
    output logic               MSR_GRANT_O,    // access granted
    output logic               MSR_DENY_O,     // access denied
    output logic [1:0]         CPL_MAX_O       // highest privilege number
);
    omc_mode_t mode;
    omc_mode_t next_mode;
    omc_mode_t saved_mode;
    logic [2:0] pin_sync;
    logic       pin_level;
    logic       pin_prev;
    logic       mgmt_pend;
    logic       enter_mgmt;
    logic       leave_mgmt;
    logic       restore_d;
    omc_env_t   next_env;

    // three-stage sync; level counts once stages two and three agree
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pin_sync <= 3'h7;
        end else begin
            pin_sync <= {pin_sync[1:0], MGMT_INT_PIN_N_I};
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            // idle level, so leaving reset gives no false edge
            pin_level <= 1'b0;
            pin_prev  <= 1'b0;
        end else begin
            if (pin_sync[1] == pin_sync[2]) begin
                pin_level <= ~pin_sync[2];
            end
            pin_prev <= pin_level;
        end
    end

    // pending request held until a boundary; new request wins over the take
    assign enter_mgmt = mgmt_pend && BOUNDARY_I && (mode != OMC_SYSMGMT);
    assign leave_mgmt = MGMT_RETURN_I && BOUNDARY_I && (mode == OMC_SYSMGMT);

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mgmt_pend <= 1'b0;
        end else if ((pin_level && !pin_prev) || LIC_MGMT_MSG_I) begin
            mgmt_pend <= 1'b1;
        end else if (enter_mgmt) begin
            mgmt_pend <= 1'b0;
        end
    end

    always_comb begin
        next_mode = mode;
        if (enter_mgmt) begin
            next_mode = OMC_SYSMGMT;
        end else if (leave_mgmt) begin
            next_mode = saved_mode;
        end else if (BOUNDARY_I && mode != OMC_SYSMGMT) begin
            if (!CTL_I.prot_en) begin
                next_mode = OMC_REAL;
            end else if (CTL_I.ext_en && CTL_I.paging_en) begin
                next_mode = CS_LONG_I ? OMC_LONG64 : OMC_COMPAT;
            end else begin
                next_mode = OMC_PROT;
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mode <= OMC_REAL;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            saved_mode <= OMC_REAL;
        end else if (enter_mgmt) begin
            saved_mode <= mode;
        end
    end

    // context lives in its own store so it survives handler activity
    omc_ctx_store #(.W(CW)) u_ctx (
        .clk_i     (CLK_I),
        .reset_n_i (RESET_N_I),
        .wr_i      (enter_mgmt),
        .wdata_i   (CTX_I),
        .rd_i      (leave_mgmt),
        .rdata_o   (CTX_O)
    );

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            CTX_SAVE_O <= 1'b0;
            restore_d  <= 1'b0;
        end else begin
            CTX_SAVE_O <= enter_mgmt;
            restore_d  <= leave_mgmt;
        end
    end
    assign CTX_RESTORE_O = restore_d;
    assign MODE_O        = mode;
    assign MGMT_SPACE_O  = (mode == OMC_SYSMGMT);

    always_comb begin
        next_env             = '0;
        next_env.addr_size   = SZ_16;
        next_env.oper_size   = SZ_16;
        next_env.lin_bits    = LIN_BITS_LEG;
        next_env.phys_bits   = PHYS_BITS_LEG;
        next_env.gpr_count   = GPR_CNT_LEG;
        next_env.ip_width    = IP_W_LEG;
        next_env.ext_regs_ok = 1'b0;
        next_env.v16_active  = 1'b0;
        next_env.task_sw_ok  = 1'b0;
        case (next_mode)
            OMC_REAL: begin
                next_env.lin_bits = LIN_BITS_LEG;
            end
            OMC_PROT: begin
                next_env.addr_size  = SZ_32;
                next_env.oper_size  = SZ_32;
                next_env.v16_active = CTL_I.v16_task;
                next_env.task_sw_ok = 1'b1;
            end
            OMC_COMPAT: begin
                next_env.addr_size  = SZ_32;
                next_env.oper_size  = SZ_32;
                next_env.lin_bits   = LIN_BITS_LEG;
                next_env.phys_bits  = CTL_I.phys_ext_en ? PHYS_BITS_64
                                                   : LIN_BITS_LEG;
                next_env.v16_active = 1'b0;
                next_env.task_sw_ok = 1'b0;
            end
            OMC_LONG64: begin
                next_env.addr_size   = SZ_64;
                next_env.oper_size   = SZ_32;
                next_env.lin_bits    = LIN_BITS_64;
                next_env.phys_bits   = PHYS_BITS_64;
                next_env.gpr_count   = GPR_CNT_WIDE;
                next_env.ip_width    = IP_W_64;
                next_env.ext_regs_ok = 1'b1;
            end
            OMC_SYSMGMT: begin
                next_env.addr_size = SZ_32;
                next_env.oper_size = SZ_32;
            end
            default: begin
                next_env.addr_size = SZ_16;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ENV_O <= '{SZ_16, SZ_16, LIN_BITS_LEG, PHYS_BITS_LEG,
                       GPR_CNT_LEG, IP_W_LEG, 1'b0, 1'b0, 1'b0};
        end else if (BOUNDARY_I) begin
            // env only moves at a boundary, so a task attribute cannot flip mid-instruction
            ENV_O <= next_env;
        end
    end

    // per-instruction operand size; only the 64-bit sub-mode promotes
    always_comb begin
        OPER_SIZE_O = ENV_O.oper_size;
        if (mode == OMC_LONG64 && REG_EXT_PFX_I && OPSZ_OVR_I) begin
            OPER_SIZE_O = SZ_64;
        end else if (OPSZ_OVR_I && ENV_O.oper_size == SZ_32) begin
            OPER_SIZE_O = SZ_16;
        end else if (OPSZ_OVR_I && ENV_O.oper_size == SZ_16) begin
            OPER_SIZE_O = SZ_32;
        end
    end

    // all four rings stay open in compatibility as in every mode but real, which caps at ring 0
    assign CPL_MAX_O = (mode == OMC_REAL) ? 2'h0 : 2'h3;

    // application level may read only the timestamp counter
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            MSR_GRANT_O <= 1'b0;
            MSR_DENY_O  <= 1'b0;
        end else begin
            MSR_GRANT_O <= MSR_REQ_I && (CPL_I == 2'h0 || MSR_ADDR_I == TSC_MSR_ADDR);
            MSR_DENY_O  <= MSR_REQ_I && CPL_I != 2'h0 && MSR_ADDR_I != TSC_MSR_ADDR;
        end
    end

    // mode and env are registered on the same edge, so checks compare same-cycle values
    chk_reset_real: assert property (@(posedge CLK_I)
        $rose(RESET_N_I) |-> mode == OMC_REAL)
        else $error("mode not real after reset");
    chk_real_env: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_REAL |-> ENV_O.addr_size == SZ_16 && CPL_MAX_O == 2'h0)
        else $error("real mode environment wrong");

    chk_mgmt_entry: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        enter_mgmt |=> mode == OMC_SYSMGMT && CTX_SAVE_O && MGMT_SPACE_O)
        else $error("management entry incomplete");
    chk_msg_pend: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        LIC_MGMT_MSG_I |=> mgmt_pend || mode == OMC_SYSMGMT)
        else $error("management message lost");
    chk_pend_hold: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_SYSMGMT && mgmt_pend |=> mgmt_pend)
        else $error("request in management mode dropped");
    chk_mgmt_exit: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        leave_mgmt |=> mode == $past(saved_mode) && CTX_RESTORE_O)
        else $error("exit did not restore mode");
    chk_boundary_only: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        !BOUNDARY_I |=> $stable(mode))
        else $error("mode changed off boundary");
    chk_env_hold: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        !BOUNDARY_I |=> $stable(ENV_O))
        else $error("environment changed off boundary");

    chk_compat_limits: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_COMPAT |-> ENV_O.lin_bits == LIN_BITS_LEG && ENV_O.addr_size != SZ_64)
        else $error("compat limits broken");
    chk_compat_tasks: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_COMPAT |-> !ENV_O.task_sw_ok && !ENV_O.v16_active)
        else $error("compat task features enabled");
    chk_compat_rings: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_COMPAT |-> CPL_MAX_O == 2'h3)
        else $error("compat privilege levels limited");
    chk_long_env: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_LONG64 |-> ENV_O.gpr_count == GPR_CNT_WIDE
            && ENV_O.ip_width == IP_W_64 && ENV_O.addr_size == SZ_64)
        else $error("64-bit environment wrong");
    chk_long_sizes: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_LONG64 |-> ENV_O.oper_size == SZ_32 && ENV_O.ext_regs_ok)
        else $error("64-bit default sizes wrong");
    chk_prefix_promote: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_LONG64 && REG_EXT_PFX_I && OPSZ_OVR_I |-> OPER_SIZE_O == SZ_64)
        else $error("operand not promoted");

    chk_msr_deny: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        MSR_REQ_I && CPL_I == 2'h3 && MSR_ADDR_I != TSC_MSR_ADDR |=> MSR_DENY_O && !MSR_GRANT_O)
        else $error("application access not denied");
    chk_tsc_grant: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        MSR_REQ_I && MSR_ADDR_I == TSC_MSR_ADDR |=> MSR_GRANT_O && !MSR_DENY_O)
        else $error("timestamp access not granted");
    chk_legacy_space: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode == OMC_PROT |-> ENV_O.phys_bits == PHYS_BITS_LEG && ENV_O.gpr_count == GPR_CNT_LEG)
        else $error("legacy limits wrong");
    chk_legacy_regs: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        mode != OMC_LONG64 |-> ENV_O.gpr_count == GPR_CNT_LEG && ENV_O.ip_width == IP_W_LEG)
        else $error("legacy register set wrong");
endmodule : omc_mode_ctrl
`default_nettype wire

// ---- design/omc_pkg.sv ----
// Purpose: shared constants and types for the operating mode controller
// Assumes: one core clock, mode control words supplied by the core
// Notes:   mode codes are one-hot
package omc_pkg;

    localparam int          CTX_W          = 96;
    localparam logic [95:0] CTX_RESET      = 96'h0;
    localparam int          GPR_LEGACY     = 8;
    localparam int          GPR_WIDE       = 16;
    localparam int          SEG_REGS       = 6;
    localparam int          SIZE_16        = 16;
    localparam int          SIZE_32        = 32;
    localparam int          SIZE_64        = 64;
    localparam logic [6:0]  LIN_BITS_LEG   = 7'h20;
    localparam logic [6:0]  LIN_BITS_64    = 7'h40;
    localparam logic [6:0]  PHYS_BITS_LEG  = 7'h24;
    localparam logic [6:0]  PHYS_BITS_64   = 7'h28;
    localparam logic [1:0]  SZ_16          = 2'h0;
    localparam logic [1:0]  SZ_32          = 2'h1;
    localparam logic [1:0]  SZ_64          = 2'h2;
    localparam logic [4:0]  GPR_CNT_LEG    = 5'h08;
    localparam logic [4:0]  GPR_CNT_WIDE   = 5'h10;
    localparam logic [6:0]  IP_W_LEG       = 7'h20;
    localparam logic [6:0]  IP_W_64        = 7'h40;
    localparam int          TSC_MSR_INDEX  = 16;
    localparam logic [31:0] TSC_MSR_ADDR   = 32'h0000_0010;

    typedef enum logic [4:0] {
        OMC_REAL   = 5'b00001,
        OMC_PROT   = 5'b00010,
        OMC_COMPAT = 5'b00100,
        OMC_LONG64 = 5'b01000,
        OMC_SYSMGMT = 5'b10000
    } omc_mode_t;

    // five mode control words as the core hands them over
    typedef struct packed {
        logic        prot_en;
        logic        paging_en;
        logic        phys_ext_en;
        logic        ext_en;
        logic        v16_task;
    } omc_ctl_t;

    typedef struct packed {
        logic [1:0]  addr_size;
        logic [1:0]  oper_size;
        logic [6:0]  lin_bits;
        logic [6:0]  phys_bits;
        logic [4:0]  gpr_count;
        logic [6:0]  ip_width;
        logic        ext_regs_ok;
        logic        v16_active;
        logic        task_sw_ok;
    } omc_env_t;

endpackage : omc_pkg

// ---- design/omc_ctx_store.sv ----
// Purpose: holds the interrupted program context across management mode
// Assumes: one save and one restore per management episode
// Notes:   read data comes from a register
`timescale 1ns/1ps
`default_nettype none
module omc_ctx_store
    import omc_pkg::*;
#(
    parameter int W = CTX_W
) (
    input  wire logic         clk_i,       // core clock
    input  wire logic         reset_n_i,   // async reset, low
    input  wire logic         wr_i,        // save strobe
    input  wire logic [W-1:0] wdata_i,     // context in
    input  wire logic         rd_i,        // restore strobe
    output logic      [W-1:0] rdata_o      // context out, registered
);
    logic [W-1:0] mem;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem <= '0;
        end else if (wr_i) begin
            mem <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= mem;
        end
    end
endmodule : omc_ctx_store
`default_nettype wire

// ---- verif/omc_mgmt_src.sv ----
// Purpose: platform side that raises management requests toward the core
// Assumes: pin idles high through a pull-up, message shares the core clock
// Notes:   pin low time is chosen by the caller to clear the synchroniser
`timescale 1ns/1ps
`default_nettype none
module omc_mgmt_src (
    input  wire logic clk_i,     // core clock
    output logic      pin_n_o,   // management pin, low active
    output logic      msg_o      // controller message pulse
);
    initial begin
        pin_n_o = 1'b1;
        msg_o   = 1'b0;
    end

    // level held low, released back to the pull-up level
    task automatic raise_pin(input int cycles);
        @(posedge clk_i);
        pin_n_o <= 1'b0;
        repeat (cycles) @(posedge clk_i);
        pin_n_o <= 1'b1;
    endtask : raise_pin

    task automatic raise_msg();
        @(posedge clk_i);
        msg_o <= 1'b1;
        @(posedge clk_i);
        msg_o <= 1'b0;
    endtask : raise_msg
endmodule : omc_mgmt_src
`default_nettype wire

// ---- verif/omc_mode_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the operating mode controller
// Assumes: mode answers one cycle after a boundary edge
// Notes:   pulses are polled each cycle under a bounded count
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl_tb_top;
    import omc_pkg::*;
    localparam logic [95:0] CTX_A = 96'hA5A5_0123_4567_89AB_CDEF_5A5A;
    localparam logic [95:0] CTX_B = 96'h1111_2222_3333_4444_5555_6666;
    logic        clk, reset_n, bnd, cs_long, ret, ext_pfx, opsz, msr_req;
    logic        pin_n, msg, space, save, restore, grant, deny;
    omc_ctl_t    ctl;
    logic [95:0] ctx, ctx_out;
    logic [1:0]  cpl, oper_size, cpl_max;
    logic [31:0] msr_addr;
    omc_mode_t   mode;
    omc_env_t    env;
    int          n_fail, check_count;

    omc_mgmt_src i_src (.clk_i(clk), .pin_n_o(pin_n), .msg_o(msg));
    omc_mode_ctrl i_dut (
        .CLK_I(clk), .RESET_N_I(reset_n), .MGMT_INT_PIN_N_I(pin_n),
        .LIC_MGMT_MSG_I(msg), .BOUNDARY_I(bnd), .CTL_I(ctl), .CS_LONG_I(cs_long),
        .MGMT_RETURN_I(ret), .CTX_I(ctx), .REG_EXT_PFX_I(ext_pfx), .OPSZ_OVR_I(opsz),
        .CPL_I(cpl), .MSR_REQ_I(msr_req), .MSR_ADDR_I(msr_addr), .MODE_O(mode),
        .ENV_O(env), .MGMT_SPACE_O(space), .CTX_SAVE_O(save),
        .CTX_RESTORE_O(restore), .CTX_O(ctx_out), .OPER_SIZE_O(oper_size),
        .MSR_GRANT_O(grant), .MSR_DENY_O(deny), .CPL_MAX_O(cpl_max));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic chk_mode(input omc_mode_t exp);
        chk("mode", 96'(exp), 96'(mode));
    endtask : chk_mode

    task automatic chk_env(input logic [6:0] lin, phys, input logic [4:0] gpr,
                           input logic [6:0] ipw);
        chk("lin_bits", 96'(lin), 96'(env.lin_bits));
        chk("phys_bits", 96'(phys), 96'(env.phys_bits));
        chk("gpr_count", 96'(gpr), 96'(env.gpr_count));
        chk("ip_width", 96'(ipw), 96'(env.ip_width));
    endtask : chk_env

    // control words taken at a boundary, answer one cycle later
    task automatic go(input logic [4:0] c, input logic cs);
        @(posedge clk);
        ctl     <= omc_ctl_t'(c);
        cs_long <= cs;
        bnd     <= 1'b1;
        @(posedge clk);
        #1;
    endtask : go

    task automatic scen_reset();
        chk_mode(OMC_REAL);
        chk_env(LIN_BITS_LEG, PHYS_BITS_LEG, GPR_CNT_LEG, IP_W_LEG);
        chk("cpl_max_real", 96'(2'h0), 96'(cpl_max));
    endtask : scen_reset

    task automatic scen_legacy();
        @(posedge clk);
        ctl <= omc_ctl_t'(5'h10);
        bnd <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_mode(OMC_REAL);
        go(5'h10, 1'b0);
        chk_mode(OMC_PROT);
        chk_env(LIN_BITS_LEG, PHYS_BITS_LEG, GPR_CNT_LEG, IP_W_LEG);
        chk("cpl_max_prot", 96'(2'h3), 96'(cpl_max));
        chk("tsw_prot", 96'(1), 96'(env.task_sw_ok));
        go(5'h11, 1'b0);
        chk_mode(OMC_PROT);
        chk("v16_prot", 96'(1), 96'(env.v16_active));
        @(posedge clk);
        ctl <= omc_ctl_t'(5'h10);
        bnd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("v16_hold", 96'(1), 96'(env.v16_active));
        go(5'h00, 1'b0);
        chk_mode(OMC_REAL);
    endtask : scen_legacy

    task automatic scen_ext();
        go(5'h1A, 1'b1);
        chk_mode(OMC_LONG64);
        chk_env(LIN_BITS_64, PHYS_BITS_64, GPR_CNT_WIDE, IP_W_64);
        chk("addr64", 96'(SZ_64), 96'(env.addr_size));
        chk("oper64", 96'(SZ_32), 96'(env.oper_size));
        chk("ext_regs", 96'(1), 96'(env.ext_regs_ok));
        chk("opsz_plain", 96'(SZ_32), 96'(oper_size));
        @(posedge clk);
        ext_pfx <= 1'b1;
        opsz    <= 1'b1;
        #1;
        chk("opsz_prefix", 96'(SZ_64), 96'(oper_size));
        go(5'h1E, 1'b0);
        chk_mode(OMC_COMPAT);
        chk_env(LIN_BITS_LEG, PHYS_BITS_64, GPR_CNT_LEG, IP_W_LEG);
        chk("cmp_opsz", 96'(SZ_16), 96'(oper_size));
        chk("cmp_addr", 96'(SZ_32), 96'(env.addr_size));
        chk("cmp_cpl", 96'(2'h3), 96'(cpl_max));
        go(5'h1B, 1'b0);
        chk("cmp_phys", 96'(LIN_BITS_LEG), 96'(env.phys_bits));
        chk("cmp_v16", 96'(0), 96'(env.v16_active));
        chk("cmp_tsw", 96'(0), 96'(env.task_sw_ok));
        chk("cmp_ext", 96'(0), 96'(env.ext_regs_ok));
        @(posedge clk);
        ext_pfx <= 1'b0;
        opsz    <= 1'b0;
    endtask : scen_ext

    // entry waits for a boundary, return must bring back the saved context
    task automatic scen_mgmt(input bit use_pin, input logic [4:0] c, input omc_mode_t prior);
        go(c, prior == OMC_LONG64);
        @(posedge clk);
        bnd <= 1'b0;
        ctx <= CTX_A;
        if (use_pin) i_src.raise_pin(6);
        else i_src.raise_msg();
        repeat (6) @(posedge clk);
        #1;
        chk_mode(prior);
        @(posedge clk);
        bnd <= 1'b1;
        #1;
        for (int i = 0; i < 8 && save !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("save", 96'(1), 96'(save));
        chk_mode(OMC_SYSMGMT);
        chk("space", 96'(1), 96'(space));
        @(posedge clk);
        ctx <= CTX_B;
        ctl <= omc_ctl_t'(5'h00);
        repeat (2) @(posedge clk);
        #1;
        chk_mode(OMC_SYSMGMT);
        @(posedge clk);
        ret <= 1'b1;
        ctl <= omc_ctl_t'(c);
        @(posedge clk);
        ret <= 1'b0;
        #1;
        for (int i = 0; i < 8 && restore !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("restore", 96'(1), 96'(restore));
        chk("ctx_out", CTX_A, ctx_out);
        chk_mode(prior);
        chk("space_off", 96'(0), 96'(space));
    endtask : scen_mgmt

    task automatic msr(input logic [1:0] c, input logic [31:0] a, input logic g);
        @(posedge clk);
        msr_req  <= 1'b1;
        cpl      <= c;
        msr_addr <= a;
        @(posedge clk);
        msr_req  <= 1'b0;
        #1;
        chk("grant", 96'(g), 96'(grant));
        chk("deny", 96'(!g), 96'(deny));
    endtask : msr

    // request left pending in management mode must not survive a reset
    task automatic scen_mid_reset();
        go(5'h1A, 1'b1);
        i_src.raise_msg();
        repeat (2) @(posedge clk);
        #1;
        chk_mode(OMC_SYSMGMT);
        i_src.raise_msg();
        repeat (2) @(posedge clk);
        #1;
        chk_mode(OMC_SYSMGMT);
        @(posedge clk);
        reset_n <= 1'b0;
        #1;
        chk_mode(OMC_REAL);
        chk("ctx_rst", 96'(0), ctx_out);
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk_mode(OMC_REAL);
        @(posedge clk);
        #1;
        chk_mode(OMC_LONG64);
    endtask : scen_mid_reset

    task automatic finish_test();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        #(20000 * 5);
        n_fail++;
        finish_test();
    end

    initial begin
        {reset_n, bnd, cs_long, ret, ext_pfx, opsz, msr_req} = '0;
        ctl = omc_ctl_t'(5'h00);
        ctx = '0;
        cpl = 2'h0;
        msr_addr = 32'h0;
        n_fail = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        #1;
        scen_reset();
        @(posedge clk);
        reset_n <= 1'b1;
        scen_legacy();
        scen_ext();
        scen_mgmt(1'b0, 5'h1A, OMC_LONG64);
        scen_mgmt(1'b1, 5'h10, OMC_PROT);
        msr(2'h3, TSC_MSR_ADDR, 1'b1);
        msr(2'h3, 32'h0000_0011, 1'b0);
        msr(2'h0, 32'h0000_0011, 1'b1);
        scen_mid_reset();
        finish_test();
    end
endmodule : omc_mode_ctrl_tb_top
`default_nettype wire
